// ---- rtl/fcs_cfg.svh ----
/*
 * constants for the clock source mode control: codes, reset values, counts, register addresses.
 * assumes it is included by the package, the design file and the assertion file only.
 */
`ifndef FCS_CFG_SVH
`define FCS_CFG_SVH

`define FCS_SRC_FLL        2'h0
`define FCS_SRC_INT        2'h1
`define FCS_SRC_EXT        2'h2
`define FCS_SRC_RSVD       2'h3
`define FCS_RST_SRC        2'h0
`define FCS_RST_REFSEL     1'h1
`define FCS_RST_BUSDIV     2'h1
`define FCS_RST_REFDIV     3'h0
`define FCS_SWITCH_CYCLES  2'h2
`define FCS_FLL_MULT       10'h200
`define FCS_FFE_MARGIN     3'h2
`define FCS_ADR_CTRL1      2'h0
`define FCS_ADR_CTRL2      2'h1
`define FCS_ADR_TRIM       2'h2
`define FCS_ADR_STAT       2'h3

`endif

// ---- rtl/fcs_pkg.sv ----
/*
 * types for the clock source mode control block.
 * assumes fcs_cfg.svh holds all numeric constants.
 */
`include "fcs_cfg.svh"

package fcs_pkg;
	typedef enum logic [2:0] {
		FCS_ENG_INT  = 3'b000,
		FCS_ENG_EXT  = 3'b001,
		FCS_BYP_INT  = 3'b010,
		FCS_BYP_INTL = 3'b011,
		FCS_BYP_EXT  = 3'b100,
		FCS_BYP_EXTL = 3'b101
	} fcs_mode_t;

	typedef struct packed {
		logic [1:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} fcs_bus_req_t;

	typedef struct packed {
		logic internal_ref;
		logic external_ref;
		logic fll;
		logic external_ok;
		logic internal_ok;
		logic fll_ok;
	} fcs_clk_in_t;
endpackage

// ---- rtl/fcs_ctrl.sv ----
/*
 * clock source mode control: mode decode, source switching, bus divider,
 * reference outputs, fixed frequency clock and its ratio flag.
 * assumes the reference clocks and the fll clock are slow against clk and
 * arrive as sampled levels; the oscillators themselves sit outside.
 */
// The register addresses and the plain strobed port were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "fcs_cfg.svh"

// How it works
// [R01] src 01, refsel 1, debug or fll on: internal bypass, fll locked, link clock on
// [R02] src 01, refsel 1, no debug, low power: internal ref, fll off, no link clock
// [R03] src 10, refsel 0, debug or fll on: external bypass, fll locked, link clock on
// [R04] src 10, refsel 0, no debug, low power: external ref, fll off, no link clock
// [R05] stop holds clocks; internal ref runs if enable and stop keep set
// [R06] in stop external ref runs only if enable and stop keep set
// [R07] refsel change accepted anytime; fll relocks after few divided ref cycles (code counts two cycles of the undivided reference)
// [R08] software updates reference divider with refsel or source changes
// [R09] source switch waits few new clock cycles; stays if new clock dead
// [R10] bus divider change applies immediately
// [R11] low power bit disables fll in bypass modes only
// [R12] internal ref enable presents internal ref on its output
// [R13] period adjust lengthens or shortens internal ref period
// [R14] period adjust values survive reset
// [R15] external ref enable presents external ref; refsel 1 keeps it off fll
// [R16] fixed frequency clock output plus ratio flag, high in engaged modes
// [R17] bypass ratio flag when reference divider >= bus divider plus two
// [R18] reset gives engaged internal mode and bus divide by two
// [R19] software copies stored trim values into period adjust fields
// [R20] software avoids divide by one before trimming
// [R21] src 00 refsel 1: engaged internal, fll on divided internal ref
// [R22] src 00 refsel 0: engaged external, fll on divided external ref
// [R23] bus divider codes divide by 1, 2, 4, 8
// [R24] clock mode status follows source only after synchronization
// [R25] switch and relock wait two full cycles of relevant clock
// [R26] source code 11 reserved, keeps current selection
module fcs_ctrl (
	// clock and reset
	input  wire logic               clk,
	input  wire logic               rst,
	// register port
	input  wire fcs_pkg::fcs_bus_req_t bus,
	output logic [7:0]              rdata,
	// system state
	input  wire logic               debug_mode_active,
	input  wire logic               stop_state,
	// clock sources, asynchronous levels
	input  wire fcs_pkg::fcs_clk_in_t clk_in,
	// trim to the internal oscillator
	output logic [7:0]              period_adjust_register,
	output logic                    fine_period_adjust,
	// clock outputs
	output logic                    main_clock_out,
	output logic                    internal_ref_out,
	output logic                    external_ref_out,
	output logic                    fixed_freq_clock,
	output logic                    fixed_freq_ratio_ok,
	output logic                    debug_link_clock,
	output logic                    fll_enable,
	output logic                    fll_ref_external,
	output logic [9:0]              fll_multiplier,
	output logic [1:0]              clock_mode_status,
	output fcs_pkg::fcs_mode_t      mode
);
	import fcs_pkg::*;

	logic [1:0] source_select_ff;
	logic       reference_select_ff;
	logic [2:0] reference_divider_ff;
	logic [1:0] bus_divider_ff;
	logic       fll_off_in_bypass_ff;
	logic       internal_ref_out_enable_ff;
	logic       internal_ref_stop_keep_ff;
	logic       external_ref_out_enable_ff;
	logic       external_ref_stop_keep_ff;
	logic [7:0] trim_ff;
	logic       fine_period_adjust_ff;
	logic [5:0] sync1_ff;
	logic [5:0] sync2_ff;
	logic [5:0] prev_ff;
	logic [1:0] active_src_ff;
	logic [1:0] sw_cnt_ff;
	logic [1:0] relock_cnt_ff;
	logic       fll_ref_sel_ff;
	logic [2:0] div_cnt_ff;
	logic [2:0] ff_cnt_ff;
	logic       ffclk_ff;
	logic [7:0] rdata_ff;
	logic [2:0] nxt_div_cnt;
	logic [1:0] cur_src_s;
	logic       iref_s;
	logic       eref_s;
	logic       fll_s;
	logic       iok_s;
	logic       eok_s;
	logic       fok_s;
	logic       ref_div_s;
	logic       rise_new;
	logic       rise_ref;
	logic       new_ok;
	logic       new_clk;
	logic       sel_clk;
	logic       bypass;
	logic       low_power;

	// two-flop synchronisers; first stage read only by the second
	always_ff @(posedge clk) begin
		if (rst) begin
			sync1_ff <= 6'h00;
			sync2_ff <= 6'h00;
		end else begin
			sync1_ff <= clk_in;
			sync2_ff <= sync1_ff;
		end
	end

	assign {iref_s, eref_s, fll_s, eok_s, iok_s, fok_s} = sync2_ff;

	// edge history of synchronised clocks
	always_ff @(posedge clk) begin
		if (rst)
			prev_ff <= 6'h00;
		else
			prev_ff <= sync2_ff;
	end

	// control writes; reserved source code leaves selection alone
	always_ff @(posedge clk) begin
		if (rst) begin
			source_select_ff           <= `FCS_RST_SRC; // [R18]
			reference_select_ff        <= `FCS_RST_REFSEL; // [R18]
			reference_divider_ff       <= `FCS_RST_REFDIV;
			bus_divider_ff             <= `FCS_RST_BUSDIV; // [R18]
			fll_off_in_bypass_ff       <= 1'b0;
			internal_ref_out_enable_ff <= 1'b0;
			internal_ref_stop_keep_ff  <= 1'b0;
			external_ref_out_enable_ff <= 1'b0;
			external_ref_stop_keep_ff  <= 1'b0;
		end else if (bus.wr && bus.addr == `FCS_ADR_CTRL1) begin
			if (bus.wdata[7:6] != `FCS_SRC_RSVD) // [R26]
				source_select_ff <= bus.wdata[7:6];
			reference_divider_ff       <= bus.wdata[5:3]; // [R07]
			reference_select_ff        <= bus.wdata[2]; // [R07]
			internal_ref_out_enable_ff <= bus.wdata[1];
			internal_ref_stop_keep_ff  <= bus.wdata[0];
		end else if (bus.wr && bus.addr == `FCS_ADR_CTRL2) begin
			bus_divider_ff             <= bus.wdata[7:6]; // [R10]
			fll_off_in_bypass_ff       <= bus.wdata[3];
			external_ref_out_enable_ff <= bus.wdata[1];
			external_ref_stop_keep_ff  <= bus.wdata[0];
		end
	end

	// trim is kept through reset: no reset branch on purpose
	always_ff @(posedge clk) begin
		if (bus.wr && bus.addr == `FCS_ADR_TRIM) // [R14]
			trim_ff <= bus.wdata;
		if (bus.wr && bus.addr == `FCS_ADR_STAT) // [R14]
			fine_period_adjust_ff <= bus.wdata[0];
	end

	assign period_adjust_register = trim_ff; // [R13]
	assign fine_period_adjust     = fine_period_adjust_ff; // [R13]

	// candidate source and its health
	always_comb begin
		case (source_select_ff)
			`FCS_SRC_INT: begin
				new_clk = iref_s;
				new_ok  = iok_s;
			end
			`FCS_SRC_EXT: begin
				new_clk = eref_s;
				new_ok  = eok_s;
			end
			default: begin
				new_clk = fll_s;
				new_ok  = fok_s;
			end
		endcase
	end

	assign rise_new = new_clk && !(source_select_ff == `FCS_SRC_INT ? prev_ff[5] :
		source_select_ff == `FCS_SRC_EXT ? prev_ff[4] : prev_ff[3]);

	// glitch-free switch after two full new-clock cycles; dead clock never switches
	always_ff @(posedge clk) begin
		if (rst) begin
			active_src_ff <= `FCS_RST_SRC;
			sw_cnt_ff     <= 2'h0;
		end else if (source_select_ff == active_src_ff || !new_ok) begin
			sw_cnt_ff <= 2'h0; // [R09]
		end else if (rise_new) begin
			if (sw_cnt_ff == `FCS_SWITCH_CYCLES) begin // [R25]
				active_src_ff <= source_select_ff; // [R09]
				sw_cnt_ff     <= 2'h0;
			end else
				sw_cnt_ff <= sw_cnt_ff + 2'h1;
		end
	end

	assign clock_mode_status = active_src_ff; // [R24]

	// fll reference follows refsel after two cycles of the current, undivided reference
	assign ref_div_s = fll_ref_sel_ff ? iref_s : eref_s;
	assign rise_ref  = ref_div_s && !(fll_ref_sel_ff ? prev_ff[5] : prev_ff[4]);

	always_ff @(posedge clk) begin
		if (rst) begin
			fll_ref_sel_ff <= `FCS_RST_REFSEL;
			relock_cnt_ff  <= 2'h0;
		end else if (reference_select_ff == fll_ref_sel_ff) begin
			relock_cnt_ff <= 2'h0;
		end else if (rise_ref || !(fll_ref_sel_ff ? iok_s : eok_s)) begin
			if (relock_cnt_ff == `FCS_SWITCH_CYCLES) begin // [R25]
				fll_ref_sel_ff <= reference_select_ff; // [R07]
				relock_cnt_ff  <= 2'h0;
			end else
				relock_cnt_ff <= relock_cnt_ff + 2'h1;
		end
	end

	assign fll_ref_external = !fll_ref_sel_ff; // [R15]

	// mode decode
	assign bypass    = active_src_ff != `FCS_SRC_FLL;
	assign low_power = fll_off_in_bypass_ff && !debug_mode_active; // [R11]

	always_comb begin
		case (active_src_ff)
			`FCS_SRC_INT: mode = low_power ? FCS_BYP_INTL : FCS_BYP_INT; // [R01] [R02]
			`FCS_SRC_EXT: mode = low_power ? FCS_BYP_EXTL : FCS_BYP_EXT; // [R03] [R04]
			default:      mode = reference_select_ff ? FCS_ENG_INT : FCS_ENG_EXT; // [R21] [R22]
		endcase
	end

	assign fll_enable       = !stop_state && !(bypass && low_power); // [R11] [R02] [R04]
	assign fll_multiplier   = `FCS_FLL_MULT; // [R01] [R03]
	assign debug_link_clock = fll_enable && fll_s; // [R01] [R02] [R03] [R04]

	// selected clock; stop holds the divider and drives the output low, not this mux
	always_comb begin
		case (active_src_ff)
			`FCS_SRC_INT: sel_clk = iref_s;
			`FCS_SRC_EXT: sel_clk = eref_s;
			default:      sel_clk = fll_s;
		endcase
	end

	// bus divider counter on selected clock rising edges; code read live
	// one history tap per source, so this edge test matches the switch logic
	always_comb begin
		nxt_div_cnt = div_cnt_ff;
		if (sel_clk && !(active_src_ff == `FCS_SRC_INT ? prev_ff[5] :
			active_src_ff == `FCS_SRC_EXT ? prev_ff[4] : prev_ff[3]))
			nxt_div_cnt = div_cnt_ff + 3'h1;
	end

	always_ff @(posedge clk) begin
		if (rst)
			div_cnt_ff <= 3'h0;
		else if (!stop_state)
			div_cnt_ff <= nxt_div_cnt;
	end

	// bit n of the counter divides by 2**(n+1); no resync so change is immediate
	always_ff @(posedge clk) begin
		if (rst)
			main_clock_out <= 1'b0;
		else if (stop_state)
			main_clock_out <= 1'b0; // [R05]
		else case (bus_divider_ff) // [R10] [R23]
			2'h0: main_clock_out <= sel_clk;
			2'h1: main_clock_out <= div_cnt_ff[0];
			2'h2: main_clock_out <= div_cnt_ff[1];
			default: main_clock_out <= div_cnt_ff[2];
		endcase
	end

	// reference outputs
	always_ff @(posedge clk) begin
		if (rst) begin
			internal_ref_out <= 1'b0;
			external_ref_out <= 1'b0;
		end else begin
			internal_ref_out <= iref_s && internal_ref_out_enable_ff &&
				(!stop_state || internal_ref_stop_keep_ff); // [R05] [R12]
			external_ref_out <= eref_s && external_ref_out_enable_ff &&
				(!stop_state || external_ref_stop_keep_ff); // [R06] [R15]
		end
	end

	// fixed frequency clock: fll reference divided by 2**(reference_divider+1), at most by 16
	always_ff @(posedge clk) begin
		if (rst) begin
			ff_cnt_ff <= 3'h0;
			ffclk_ff  <= 1'b0;
		end else if (stop_state) begin
			ffclk_ff <= 1'b0; // [R05]
		end else if (rise_ref) begin
			ff_cnt_ff <= ff_cnt_ff + 3'h1;
			if (reference_divider_ff == 3'h0)
				ffclk_ff <= !ffclk_ff;
			else if (ff_cnt_ff == (3'h7 >> (3'h3 - (reference_divider_ff > 3'h3 ? 3'h3 :
				reference_divider_ff)))) begin
				ff_cnt_ff <= 3'h0;
				ffclk_ff  <= !ffclk_ff;
			end
		end
	end

	assign fixed_freq_clock = ffclk_ff; // [R16]

	// ratio flag
	always_ff @(posedge clk) begin
		if (rst)
			fixed_freq_ratio_ok <= 1'b1;
		else
			fixed_freq_ratio_ok <= !bypass || // [R16]
				(reference_divider_ff >= {1'b0, bus_divider_ff} + `FCS_FFE_MARGIN); // [R17]
	end

	// read port, data one cycle after strobe
	always_ff @(posedge clk) begin
		if (rst)
			rdata_ff <= 8'h00;
		else if (bus.rd) case (bus.addr)
			`FCS_ADR_CTRL1: rdata_ff <= {source_select_ff, reference_divider_ff,
				reference_select_ff, internal_ref_out_enable_ff, internal_ref_stop_keep_ff};
			`FCS_ADR_CTRL2: rdata_ff <= {bus_divider_ff, 2'h0, fll_off_in_bypass_ff, 1'b0,
				external_ref_out_enable_ff, external_ref_stop_keep_ff};
			`FCS_ADR_TRIM:  rdata_ff <= trim_ff;
			default:        rdata_ff <= {4'h0, active_src_ff, 1'b0, fine_period_adjust_ff}; // [R24]
		endcase
	end

	assign rdata = rdata_ff;
endmodule
`default_nettype wire

// ---- testbench/fcs_src_model.sv ----
/*
 * model of the three clock sources that feed the clock control.
 * assumes the bench runs clk at 10 ns; a source that is off parks low.
 */
`timescale 1ns/1ns
`default_nettype none
module fcs_src_model (
	// source enables from the bench
	input  wire logic            int_on,
	input  wire logic            ext_on,
	// sources to the block
	output fcs_pkg::fcs_clk_in_t clk_in
);
	import fcs_pkg::*;
	logic ir = 1'b0;
	logic er = 1'b0;
	logic fl = 1'b0;
	// offset by 3 ns so no source edge meets a clk edge
	initial #3 forever #100 ir = int_on ? ~ir : 1'b0;
	initial #3 forever #60 er = ext_on ? ~er : 1'b0;
	initial #3 forever #20 fl = ~fl;
	assign clk_in = '{internal_ref: ir, external_ref: er, fll: fl,
		external_ok: ext_on, internal_ok: int_on, fll_ok: 1'b1};
endmodule
`default_nettype wire

// ---- testbench/fcs_ctrl_sva.sv ----
/*
 * port assertions for the clock source mode control.
 * assumes the bind below; one clock with synchronous reset.
 */
`timescale 1ns/1ns
`default_nettype none
`include "fcs_cfg.svh"
module fcs_ctrl_sva (
	// clock and reset
	input wire logic                  clk,
	input wire logic                  rst,
	// inputs
	input wire fcs_pkg::fcs_bus_req_t bus,
	input wire logic                  debug_mode_active,
	input wire logic                  stop_state,
	// outputs
	input wire logic [7:0]            period_adjust_register,
	input wire logic                  main_clock_out,
	input wire logic                  fixed_freq_clock,
	input wire logic                  fixed_freq_ratio_ok,
	input wire logic                  debug_link_clock,
	input wire logic                  fll_enable,
	input wire logic [9:0]            fll_multiplier,
	input wire logic [1:0]            clock_mode_status,
	input wire fcs_pkg::fcs_mode_t    mode
);
	import fcs_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// mode groups
	wire lp = mode inside {FCS_BYP_INTL, FCS_BYP_EXTL};
	wire eng = mode inside {FCS_ENG_INT, FCS_ENG_EXT};
	sequence stop_s; stop_state [*3]; endsequence
	sequence dbg_s; debug_mode_active [*2]; endsequence
	lp_fll_a: assert property (lp |-> !fll_enable && !debug_link_clock)
		else $error("fll running in low power bypass");
	// stop parks the fll as well, so only a running part is held to it
	fll_run_a: assert property (!lp && !stop_state
		|-> fll_enable && fll_multiplier == `FCS_FLL_MULT) else $error("fll off outside low power");
	dbg_mode_a: assert property (dbg_s |-> !lp)
		else $error("low power mode under debug");
	eng_flag_a: assert property (eng [*2] |-> fixed_freq_ratio_ok)
		else $error("ratio flag low in engaged mode");
	stat_code_a: assert property (clock_mode_status != `FCS_SRC_RSVD)
		else $error("reserved status code");
	stat_lag_a: assert property (bus.wr && bus.addr == `FCS_ADR_CTRL1
		|=> $stable(clock_mode_status) [*2]) else $error("status moved at once");
	trim_wr_a: assert property (bus.wr && bus.addr == `FCS_ADR_TRIM
		|=> period_adjust_register == $past(bus.wdata)) else $error("trim write lost");
	stop_hold_a: assert property (stop_s
		|-> $stable(main_clock_out) && $stable(fixed_freq_clock)) else $error("clock in stop");
endmodule
bind fcs_ctrl fcs_ctrl_sva i_fcs_ctrl_sva (.clk(clk), .rst(rst), .bus(bus),
	.debug_mode_active(debug_mode_active), .stop_state(stop_state),
	.period_adjust_register(period_adjust_register), .main_clock_out(main_clock_out),
	.fixed_freq_clock(fixed_freq_clock), .fixed_freq_ratio_ok(fixed_freq_ratio_ok),
	.debug_link_clock(debug_link_clock), .fll_enable(fll_enable),
	.fll_multiplier(fll_multiplier), .clock_mode_status(clock_mode_status), .mode(mode));
`default_nettype wire

// ---- testbench/testbench.sv ----
/*
 * bench for the clock source mode control: mode table, divider, stop.
 * assumes fcs_src_model supplies the sources and the checker is bound.
 */
`timescale 1ns/1ns
`default_nettype none
module testbench;
	import fcs_pkg::*;
	logic clk = 1'b0, rst = 1'b1, dbg = 1'b0, stp = 1'b0, ion = 1'b1, eon = 1'b1;
	fcs_bus_req_t bus = '0;
	fcs_clk_in_t  ci;
	fcs_mode_t    md;
	logic [7:0]   rdata, trim, d;
	logic [9:0]   mul;
	logic [1:0]   st;
	logic         ftr, mco, iro, ero, ffc, ffe, dlc, fen, fre;
	int           miscompares = 0, checks = 0, n, m;
	// ctrl1, ctrl2, debug, mode, status
	logic [21:0] tbl [8] = '{22'h011000, 22'h001004, 22'h111009, 22'h11120d,
		22'h111229, 22'h201012, 22'h201216, 22'h011000};
	always #5 clk = ~clk;
	fcs_src_model i_fcs_src_model (.int_on(ion), .ext_on(eon), .clk_in(ci));
	fcs_ctrl i_fcs_ctrl (.clk(clk), .rst(rst), .bus(bus), .rdata(rdata),
		.debug_mode_active(dbg), .stop_state(stp), .clk_in(ci),
		.period_adjust_register(trim), .fine_period_adjust(ftr), .main_clock_out(mco),
		.internal_ref_out(iro), .external_ref_out(ero), .fixed_freq_clock(ffc),
		.fixed_freq_ratio_ok(ffe), .debug_link_clock(dlc), .fll_enable(fen),
		.fll_ref_external(fre), .fll_multiplier(mul), .clock_mode_status(st), .mode(md));
	task automatic chk(input logic [9:0] g, input logic [9:0] e);
		checks++;
		if (g !== e) begin
			miscompares++;
			$display("[ERR] %0t got %h want %h", $time, g, e);
		end
	endtask
	// strobes go out on a rising edge; results read at a falling edge
	task automatic wr(input logic [1:0] a, input logic [7:0] v);
		@(posedge clk);
		bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		bus <= '0;
		repeat (2) @(negedge clk);
	endtask
	task automatic rd(input logic [1:0] a, output logic [7:0] v);
		@(posedge clk);
		bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		bus <= '0;
		@(negedge clk);
		v = rdata;
		@(negedge clk);
	endtask
	task automatic do_rst;
		@(posedge clk);
		rst <= 1'b1;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
	endtask
	task automatic wst(input logic [1:0] s);
		for (int i = 0; i < 400 && st !== s; i++) @(negedge clk);
	endtask
	// skip a few cycles so gating latency does not count as a toggle
	task automatic tog(output int a, output int b);
		logic pi, pe;
		repeat (8) @(negedge clk);
		a = 0;
		b = 0;
		pi = iro;
		pe = ero;
		repeat (200) begin
			@(negedge clk);
			a += int'(iro !== pi);
			b += int'(ero !== pe);
			pi = iro;
			pe = ero;
		end
	endtask
	task automatic print_verdict;
		if (miscompares == 0 && checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	initial begin
		do_rst();
		wr(2'h2, 8'h5a);
		wr(2'h3, 8'h01);
		do_rst();
		chk(trim, 8'h5a);
		chk(ftr, 1'b1);
		rd(2'h2, d);
		chk(d, 8'h5a);
		rd(2'h1, d);
		chk(d[7:6], 2'h1);
		chk(md, FCS_ENG_INT);
		chk(ffe, 1'b1);
		foreach (tbl[i]) begin
			@(posedge clk);
			dbg <= tbl[i][5];
			wr(2'h1, tbl[i][13:6]);
			wr(2'h0, tbl[i][21:14]);
			wst(tbl[i][1:0]);
			for (n = 0; n < 200 && fre !== !tbl[i][16]; n++) @(negedge clk);
			chk(st, tbl[i][1:0]);
			chk(md, tbl[i][4:2]);
			chk(fen, tbl[i][4:2] != 3'h3 && tbl[i][4:2] != 3'h5);
			chk(fre, !tbl[i][16]);
			// link clock must show activity unless the fll is parked
			m = 0;
			repeat (40) begin
				@(negedge clk);
				m += int'(dlc === 1'b1);
			end
			chk(m != 0, tbl[i][4:2] != 3'h3 && tbl[i][4:2] != 3'h5);
		end
		// divider code zero: fixed clock period is two reference periods
		@(posedge ffc);
		n = int'($time);
		@(posedge ffc);
		chk(10'((int'($time) - n) / 10), 10'h028);
		wr(2'h0, 8'hdc);
		rd(2'h0, d);
		chk(d[7:3], 5'h03);
		repeat (100) @(negedge clk);
		chk(st, 2'h0);
		eon <= 1'b0;
		wr(2'h0, 8'h80);
		repeat (300) @(negedge clk);
		chk(st, 2'h0);
		eon <= 1'b1;
		wst(2'h2);
		chk(st, 2'h2);
		for (int b = 0; b < 4; b++) begin
			wr(2'h1, {b[1:0], 6'h00});
			wr(2'h0, 8'h44);
			wst(2'h1);
			@(posedge mco);
			@(posedge mco);
			n = int'($time);
			@(posedge mco);
			chk(10'((int'($time) - n) / 10), 10'(20 << b));
			for (int r = 0; r < 8; r++) begin
				wr(2'h0, {2'h1, r[2:0], 3'h4});
				chk(ffe, r >= b + 2);
			end
		end
		wr(2'h1, 8'h42);
		wr(2'h0, 8'h47);
		tog(n, m);
		chk(n != 0 && m != 0, 1'b1);
		@(posedge clk);
		stp <= 1'b1;
		tog(n, m);
		chk(n != 0 && m == 0, 1'b1);
		wr(2'h0, 8'h45);
		wr(2'h1, 8'h43);
		tog(n, m);
		chk(n == 0 && m != 0, 1'b1);
		@(posedge clk);
		stp <= 1'b0;
		print_verdict();
	end
	// hang guard, a few times the expected run
	initial begin
		#200000;
		miscompares++;
		print_verdict();
	end
endmodule
`default_nettype wire
